// ---- verilog/packet_handling_config.sv ----
`timescale 1ns/1ps
`default_nettype none
module packet_handling_config #(
  parameter int PQ_W = 6
) (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // register port
  input wire logic [5:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  output logic cfg_out_valid,
  output packet_cfg_pkg::cfg_type cfg,
  // demodulated receive bits and packet events
  input wire logic rx_bit_valid,
  input wire logic rx_bit,
  input wire logic hdr_valid,
  input wire logic [7:0] hdr_byte,
  input wire logic addr_valid,
  input wire logic [7:0] addr_byte,
  input wire logic rx_end,
  input wire logic crc_ok,
  input wire logic [7:0] rssi,
  input wire logic [7:0] lqi,
  // receive results
  output logic sync_allowed,
  output logic sync_hit,
  output logic [7:0] pkt_len,
  output logic len_ok,
  output logic len_infinite,
  output logic addr_ok,
  output logic rx_flush,
  output logic status_valid,
  output logic [7:0] status_rssi,
  output logic [7:0] status_lqi_crc,
  // transmit byte stream
  input wire logic in_valid,
  input wire logic [7:0] in_data,
  output logic in_ready,
  output logic out_valid,
  output logic [7:0] out_data,
  input wire logic out_ready,
  // serial data pins
  input wire logic general_out_pin_zero,
  output logic general_out_pins,
  output logic serial_mode
);
  import packet_cfg_pkg::*;

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  // eight steps of x^9 + x^5 + 1, used for whitening and test data
  function automatic logic [8:0] pn9_byte(input logic [8:0] s);
    logic [8:0] t;
    t = s;
    for (int i = 0; i < 8; i++) begin
      t = {t[0] ^ t[5], t[8:1]};
    end
    return t;
  endfunction : pn9_byte

  // ----------------------------------------
  // registers
  // ----------------------------------------
  logic [7:0] sync_hi_q, sync_hi_d, sync_lo_q, sync_lo_d;
  logic [7:0] len_lim_q, len_lim_d, rx_ctrl_q, rx_ctrl_d;
  logic [7:0] fmt_ctrl_q, fmt_ctrl_d, dev_addr_q, dev_addr_d;
  logic [7:0] rdata_q, rdata_d;
  cfg_type cfg_q, cfg_d;

  // decode writes; unused bits masked so they never stick
  always_comb begin
    sync_hi_d = sync_hi_q;
    sync_lo_d = sync_lo_q;
    len_lim_d = len_lim_q;
    rx_ctrl_d = rx_ctrl_q;
    fmt_ctrl_d = fmt_ctrl_q;
    dev_addr_d = dev_addr_q;
    rdata_d = rdata_q;
    if (reg_wr) begin
      case (reg_addr)
        SYNC_HI_OFS: sync_hi_d = reg_wdata;
        SYNC_LO_OFS: sync_lo_d = reg_wdata;
        LEN_LIMIT_OFS: len_lim_d = reg_wdata;
        RX_CTRL_OFS: rx_ctrl_d = reg_wdata & RX_CTRL_MASK;
        FMT_CTRL_OFS: fmt_ctrl_d = reg_wdata & FMT_CTRL_MASK;
        DEV_ADDR_OFS: dev_addr_d = reg_wdata;
        default: ;
      endcase
    end
    if (reg_rd) begin
      case (reg_addr)
        SYNC_HI_OFS: rdata_d = sync_hi_q;
        SYNC_LO_OFS: rdata_d = sync_lo_q;
        LEN_LIMIT_OFS: rdata_d = len_lim_q;
        RX_CTRL_OFS: rdata_d = rx_ctrl_q;
        FMT_CTRL_OFS: rdata_d = fmt_ctrl_q;
        DEV_ADDR_OFS: rdata_d = dev_addr_q;
        default: rdata_d = 8'h00;
      endcase
    end
    cfg_d.sync_word = {sync_hi_d, sync_lo_d};
    cfg_d.length_limit = len_lim_d;
    cfg_d.preamble_quality_threshold = rx_ctrl_d[PQT_LSB +: 3];
    cfg_d.bad_check_discard = rx_ctrl_d[FLUSH_BIT];
    cfg_d.status_byte_append = rx_ctrl_d[APPEND_BIT];
    cfg_d.address_filter_select = adr_type'(rx_ctrl_d[ADR_LSB +: 2]);
    cfg_d.whitening_enable = fmt_ctrl_d[WHITE_BIT];
    cfg_d.data_path_format = fmt_type'(fmt_ctrl_d[FMT_LSB +: 2]);
    cfg_d.crc_enable = fmt_ctrl_d[CRC_BIT];
    cfg_d.length_config = len_type'(fmt_ctrl_d[LEN_LSB +: 2]);
    cfg_d.device_address = dev_addr_d;
  end

  // decoded view stays in step with the raw bytes
  always_ff @(posedge clk) begin
    if (!rstn) begin
      sync_hi_q <= SYNC_HI_RST;
      sync_lo_q <= SYNC_LO_RST;
      len_lim_q <= LEN_LIMIT_RST;
      rx_ctrl_q <= RX_CTRL_RST;
      fmt_ctrl_q <= FMT_CTRL_RST;
      dev_addr_q <= DEV_ADDR_RST;
      rdata_q <= 8'h00;
      cfg_q <= {SYNC_HI_RST, SYNC_LO_RST, LEN_LIMIT_RST, 3'h0, 1'b0,
        1'b1, ADR_NONE, 1'b1, FMT_BUFFERED, 1'b1, LEN_VARIABLE,
        DEV_ADDR_RST};
    end else begin
      sync_hi_q <= sync_hi_d;
      sync_lo_q <= sync_lo_d;
      len_lim_q <= len_lim_d;
      rx_ctrl_q <= rx_ctrl_d;
      fmt_ctrl_q <= fmt_ctrl_d;
      dev_addr_q <= dev_addr_d;
      rdata_q <= rdata_d;
      cfg_q <= cfg_d;
    end
  end
  assign reg_rdata = rdata_q;
  assign cfg = cfg_q;
  assign cfg_out_valid = 1'b1;

  // ----------------------------------------
  // preamble quality and sync search
  // ----------------------------------------
  logic [PQ_W-1:0] pq_q, pq_d;
  logic [15:0] shift_q, shift_d;
  logic prev_q, prev_d, allow_q, allow_d, hit_q, hit_d;
  logic [PQ_W-1:0] pq_need;

  // counter saturates at both ends so noise cannot wrap it
  always_comb begin
    pq_need = PQ_W'({cfg_q.preamble_quality_threshold, 2'b00});
    pq_d = pq_q;
    shift_d = shift_q;
    prev_d = prev_q;
    hit_d = 1'b0;
    if (rx_bit_valid) begin
      prev_d = rx_bit;
      shift_d = {shift_q[14:0], rx_bit};
      if (rx_bit != prev_q) begin
        if (pq_q != {PQ_W{1'b1}}) pq_d = pq_q + 1'b1;
      end else begin
        pq_d = (pq_q > PQ_W'(PQ_DOWN)) ? pq_q - PQ_W'(PQ_DOWN) : '0;
      end
    end
    allow_d = (cfg_q.preamble_quality_threshold == 3'h0)
      || (pq_d >= pq_need);
    if (rx_bit_valid && shift_d == cfg_q.sync_word && allow_d) begin
      hit_d = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      pq_q <= '0;
      shift_q <= 16'h0000;
      prev_q <= 1'b0;
      allow_q <= 1'b1;
      hit_q <= 1'b0;
    end else begin
      pq_q <= pq_d;
      shift_q <= shift_d;
      prev_q <= prev_d;
      allow_q <= allow_d;
      hit_q <= hit_d;
    end
  end
  assign sync_allowed = allow_q;
  assign sync_hit = hit_q;

  // ----------------------------------------
  // length, address, flush and status
  // ----------------------------------------
  logic [7:0] len_q, len_d, srssi_q, srssi_d, slqi_q, slqi_d;
  logic lok_q, lok_d, linf_q, linf_d, aok_q, aok_d;
  logic flush_q, flush_d, stv_q, stv_d;
  logic own, bz, bo;

  always_comb begin
    len_d = len_q;
    lok_d = lok_q;
    linf_d = linf_q;
    aok_d = aok_q;
    if (hdr_valid) begin
      case (cfg_q.length_config)
        LEN_FIXED: begin
          len_d = cfg_q.length_limit;
          lok_d = 1'b1;
          linf_d = 1'b0;
        end
        LEN_VARIABLE: begin
          len_d = hdr_byte;
          lok_d = hdr_byte <= cfg_q.length_limit;
          linf_d = 1'b0;
        end
        LEN_INFINITE: begin
          lok_d = 1'b1;
          linf_d = 1'b1;
        end
        default: begin // reserved setting never passes
          lok_d = 1'b0;
          linf_d = 1'b0;
        end
      endcase
    end
    own = addr_byte == cfg_q.device_address;
    bz = addr_byte == BCAST_ZERO;
    bo = addr_byte == BCAST_ONES;
    if (addr_valid) begin
      case (cfg_q.address_filter_select)
        ADR_NONE: aok_d = 1'b1;
        ADR_NO_BCAST: aok_d = own;
        ADR_BCAST_ZERO: aok_d = own || bz;
        default: aok_d = own || bz || bo;
      endcase
    end
    // a failed check is only known while checking is on
    flush_d = rx_end && cfg_q.bad_check_discard && cfg_q.crc_enable
      && !crc_ok;
    stv_d = rx_end && cfg_q.status_byte_append;
    srssi_d = rx_end ? rssi : srssi_q;
    slqi_d = rx_end ? {crc_ok && cfg_q.crc_enable, lqi[6:0]} : slqi_q;
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      len_q <= LEN_LIMIT_RST;
      lok_q <= 1'b0;
      linf_q <= 1'b0;
      aok_q <= 1'b0;
      flush_q <= 1'b0;
      stv_q <= 1'b0;
      srssi_q <= 8'h00;
      slqi_q <= 8'h00;
    end else begin
      len_q <= len_d;
      lok_q <= lok_d;
      linf_q <= linf_d;
      aok_q <= aok_d;
      flush_q <= flush_d;
      stv_q <= stv_d;
      srssi_q <= srssi_d;
      slqi_q <= slqi_d;
    end
  end
  assign pkt_len = len_q;
  assign len_ok = lok_q;
  assign len_infinite = linf_q;
  assign addr_ok = aok_q;
  assign rx_flush = flush_q;
  assign status_valid = stv_q;
  assign status_rssi = srssi_q;
  assign status_lqi_crc = slqi_q;

  // ----------------------------------------
  // transmit buffer and serial pins
  // ----------------------------------------
  logic [7:0] mem_q [2], mem_d [2];
  logic [1:0] cnt_q, cnt_d;
  logic wp_q, wp_d, rp_q, rp_d, ir_q, ir_d, ov_q, ov_d;
  logic [7:0] od_q, od_d, byte_in;
  logic [8:0] wht_q, wht_d, rnd_q, rnd_d;
  logic [2:0] pin_q, pin_d;
  logic lvl_q, lvl_d, ser_q, ser_d;
  logic push, pop;

  // transform on entry so a stalled word is never re-whitened
  always_comb begin
    push = in_valid && ir_q;
    pop = ov_q && out_ready;
    mem_d = mem_q;
    wht_d = wht_q;
    rnd_d = rnd_q;
    byte_in = in_data;
    if (cfg_q.data_path_format == FMT_RANDOM) byte_in = rnd_q[7:0];
    if (cfg_q.whitening_enable) byte_in = byte_in ^ wht_q[7:0];
    if (push) begin
      mem_d[wp_q] = byte_in;
      wht_d = pn9_byte(wht_q);
      rnd_d = pn9_byte(rnd_q);
    end
    wp_d = wp_q ^ push;
    rp_d = rp_q ^ pop;
    cnt_d = cnt_q + {1'b0, push} - {1'b0, pop};
    ir_d = cnt_d != 2'd2;
    ov_d = cnt_d != 2'd0;
    od_d = mem_d[rp_d];
    // pin filter: a change counts once stages two and three agree
    pin_d = {pin_q[1:0], general_out_pin_zero};
    lvl_d = (pin_q[1] == pin_q[2]) ? pin_q[2] : lvl_q;
    ser_d = cfg_q.data_path_format == FMT_SYNC_SERIAL
      || cfg_q.data_path_format == FMT_ASYNC_SERIAL;
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      mem_q <= '{8'h00, 8'h00};
      cnt_q <= 2'd0;
      wp_q <= 1'b0;
      rp_q <= 1'b0;
      ir_q <= 1'b1;
      ov_q <= 1'b0;
      od_q <= 8'h00;
      wht_q <= PN9_SEED;
      rnd_q <= PN9_SEED;
      pin_q <= 3'h0;
      lvl_q <= 1'b0;
      ser_q <= 1'b0;
    end else begin
      mem_q <= mem_d;
      cnt_q <= cnt_d;
      wp_q <= wp_d;
      rp_q <= rp_d;
      ir_q <= ir_d;
      ov_q <= ov_d;
      od_q <= od_d;
      wht_q <= wht_d;
      rnd_q <= rnd_d;
      pin_q <= pin_d;
      lvl_q <= lvl_d;
      ser_q <= ser_d;
    end
  end
  assign in_ready = ir_q;
  assign out_valid = ov_q;
  assign out_data = od_q;
  assign serial_mode = ser_q;
  assign general_out_pins = lvl_q;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  sync_reset_a: assert property (disable iff (1'b0) !rstn |=>
    cfg_q.sync_word == {SYNC_HI_RST, SYNC_LO_RST}) else
    $error("sync word reset value wrong");
  pq_up_a: assert property (rx_bit_valid && rx_bit != prev_q
    && pq_q < PQ_W'(20) |=> pq_q == $past(pq_q) + 1'b1)
    else $error("quality counter did not rise");
  pq_down_a: assert property (rx_bit_valid && rx_bit == prev_q
    && pq_q >= PQ_W'(PQ_DOWN) |=> pq_q == $past(pq_q) - PQ_W'(PQ_DOWN))
    else $error("quality counter did not fall by eight");
  sync_gate_a: assert property (hit_q |-> $past(rx_bit_valid)
    && shift_q == $past(cfg_q.sync_word)
    && ($past(cfg_q.preamble_quality_threshold) == 3'h0
    || pq_q >= $past(pq_need))) else $error("sync hit while gated");
  pqt_zero_a: assert property (cfg_q.preamble_quality_threshold == 3'h0
    && !reg_wr |=> allow_q) else $error("zero threshold gated sync");
  fixed_len_a: assert property (hdr_valid
    && cfg_q.length_config == LEN_FIXED
    |=> len_q == $past(cfg_q.length_limit) && lok_q)
    else $error("fixed length not taken");
  var_len_a: assert property (hdr_valid
    && cfg_q.length_config == LEN_VARIABLE
    |=> len_q == $past(hdr_byte) && lok_q == ($past(hdr_byte)
    <= $past(cfg_q.length_limit))) else $error("variable length wrong");
  flush_a: assert property (rx_end && !crc_ok
    && cfg_q.bad_check_discard && cfg_q.crc_enable |=> flush_q)
    else $error("bad packet not discarded");
  crc_off_a: assert property (!cfg_q.crc_enable |=> !flush_q)
    else $error("discard with CRC off");
  addr_bcast_a: assert property (addr_valid && addr_byte == BCAST_ONES
    && cfg_q.address_filter_select == ADR_BCAST_ZERO
    && cfg_q.device_address != BCAST_ONES |=> !aok_q)
    else $error("0xFF broadcast wrongly accepted");
  status_a: assert property (rx_end && cfg_q.status_byte_append
    |=> stv_q && srssi_q == $past(rssi)) else $error("status missing");
  unused_a: assert property (rx_ctrl_q[4] == 1'b0
    && fmt_ctrl_q[7] == 1'b0 && fmt_ctrl_q[3] == 1'b0)
    else $error("unused bit set");
  hold_a: assert property (ov_q && !out_ready |=> ov_q
    && $stable(od_q)) else $error("stalled word changed");

  hit_c: cover property (hit_q && cfg_q.preamble_quality_threshold != 3'h0);
  flush_c: cover property (flush_q);
  full_c: cover property (!ir_q ##1 ir_q);
endmodule : packet_handling_config
`default_nettype wire

// ---- verilog/packet_cfg_pkg.sv ----
`default_nettype none
package packet_cfg_pkg;
  // ----------------------------------------
  // register offsets and reset values
  // ----------------------------------------
  localparam logic [5:0] SYNC_HI_OFS = 6'h04;
  localparam logic [5:0] SYNC_LO_OFS = 6'h05;
  localparam logic [5:0] LEN_LIMIT_OFS = 6'h06;
  localparam logic [5:0] RX_CTRL_OFS = 6'h07;
  localparam logic [5:0] FMT_CTRL_OFS = 6'h08;
  localparam logic [5:0] DEV_ADDR_OFS = 6'h09;
  localparam logic [7:0] SYNC_HI_RST = 8'hD3;
  localparam logic [7:0] SYNC_LO_RST = 8'h91;
  localparam logic [7:0] LEN_LIMIT_RST = 8'hFF;
  localparam logic [7:0] RX_CTRL_RST = 8'h04;
  localparam logic [7:0] FMT_CTRL_RST = 8'h45;
  localparam logic [7:0] DEV_ADDR_RST = 8'h00;
  // writable bits; the rest read as zero
  localparam logic [7:0] RX_CTRL_MASK = 8'hEF;
  localparam logic [7:0] FMT_CTRL_MASK = 8'h77;
  // ----------------------------------------
  // field positions
  // ----------------------------------------
  localparam int PQT_LSB = 5;
  localparam int FLUSH_BIT = 3;
  localparam int APPEND_BIT = 2;
  localparam int ADR_LSB = 0;
  localparam int WHITE_BIT = 6;
  localparam int FMT_LSB = 4;
  localparam int CRC_BIT = 2;
  localparam int LEN_LSB = 0;
  // ----------------------------------------
  // misc constants
  // ----------------------------------------
  localparam int PQ_DOWN = 8;
  localparam logic [7:0] BCAST_ZERO = 8'h00;
  localparam logic [7:0] BCAST_ONES = 8'hFF;
  localparam logic [8:0] PN9_SEED = 9'h1FF;
  typedef enum logic [1:0] {FMT_BUFFERED, FMT_SYNC_SERIAL, FMT_RANDOM,
    FMT_ASYNC_SERIAL} fmt_type;
  typedef enum logic [1:0] {ADR_NONE, ADR_NO_BCAST, ADR_BCAST_ZERO,
    ADR_BCAST_BOTH} adr_type;
  typedef enum logic [1:0] {LEN_FIXED, LEN_VARIABLE, LEN_INFINITE,
    LEN_RESERVED} len_type;
  typedef struct packed {
    logic [15:0] sync_word;
    logic [7:0] length_limit;
    logic [2:0] preamble_quality_threshold;
    logic bad_check_discard;
    logic status_byte_append;
    adr_type address_filter_select;
    logic whitening_enable;
    fmt_type data_path_format;
    logic crc_enable;
    len_type length_config;
    logic [7:0] device_address;
  } cfg_type;
endpackage : packet_cfg_pkg
`default_nettype wire

// ---- verification/tx_sink.sv ----
`timescale 1ns/1ps
`default_nettype none
// far-side byte sink of the transmit stream; stall holds ready low
module tx_sink (
  // clock
  input wire logic clk,
  // stream from the block
  input wire logic out_valid,
  input wire logic [7:0] out_data,
  output logic out_ready,
  // bench control
  input wire logic stall
);
  logic [7:0] got[$];
  // ready moves only just after an edge, so a byte is taken on one edge only
  always @(posedge clk) begin
    if (out_valid && out_ready) got.push_back(out_data);
    out_ready <= !stall;
  end
endmodule : tx_sink
`default_nettype wire

// ---- verification/packet_handling_config_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module packet_handling_config_tb;
  import packet_cfg_pkg::*;
  // ----------------------------------------
  // stimulus and observed signals
  // ----------------------------------------
  logic clk = 1'b0, rstn = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
  logic [5:0] reg_addr = 6'h00;
  logic rx_bit_valid = 1'b0, rx_bit = 1'b0, hdr_valid = 1'b0;
  logic addr_valid = 1'b0, rx_end = 1'b0, crc_ok = 1'b0;
  logic in_valid = 1'b0, out_ready, pin_in = 1'b0, stall = 1'b1;
  logic [7:0] reg_wdata = 8'h00, hdr_byte = 8'h00, addr_byte = 8'h00;
  logic [7:0] rssi = 8'h9C, lqi = 8'hC5, in_data = 8'h00;
  logic [7:0] reg_rdata, pkt_len, out_data, status_rssi, status_lqi_crc;
  logic sync_allowed, sync_hit, len_ok, len_infinite, addr_ok, rx_flush;
  logic status_valid, in_ready, out_valid, pin_out, serial_mode;
  cfg_type cfg;
  int fail_count = 0, compares = 0;
  // 100 ns period
  initial forever #50 clk = ~clk;
  packet_handling_config #(.PQ_W(6)) dut_u (.clk(clk), .rstn(rstn),
    .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .cfg_out_valid(),
    .cfg(cfg), .rx_bit_valid(rx_bit_valid), .rx_bit(rx_bit),
    .hdr_valid(hdr_valid), .hdr_byte(hdr_byte), .addr_valid(addr_valid),
    .addr_byte(addr_byte), .rx_end(rx_end), .crc_ok(crc_ok), .rssi(rssi),
    .lqi(lqi), .sync_allowed(sync_allowed), .sync_hit(sync_hit),
    .pkt_len(pkt_len), .len_ok(len_ok), .len_infinite(len_infinite),
    .addr_ok(addr_ok), .rx_flush(rx_flush), .status_valid(status_valid),
    .status_rssi(status_rssi), .status_lqi_crc(status_lqi_crc),
    .in_valid(in_valid), .in_data(in_data), .in_ready(in_ready),
    .out_valid(out_valid), .out_data(out_data), .out_ready(out_ready),
    .general_out_pin_zero(pin_in), .general_out_pins(pin_out),
    .serial_mode(serial_mode));
  tx_sink sink_u (.clk(clk), .out_valid(out_valid), .out_data(out_data),
    .out_ready(out_ready), .stall(stall));
  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic chk(input string what, input logic [7:0] exp,
    input logic [7:0] got);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  // reference scrambler: x^9 + x^5 + 1, eight shifts per byte
  function automatic logic [8:0] lfsr8(input logic [8:0] v);
    logic [8:0] r;
    r = v;
    repeat (8) r = {r[5] ^ r[0], r[8:1]};
    return r;
  endfunction : lfsr8
  task automatic wrap_up;
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : wrap_up
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr
  // read data is registered, so it is looked at half a cycle after
  task automatic rd(input string w, input logic [5:0] a, input logic [7:0] e);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(negedge clk);
    chk(w, e, reg_rdata);
  endtask : rd
  // received bits, oldest first, back to back
  task automatic bits(input logic [15:0] v, input int n);
    for (int i = n - 1; i >= 0; i--) begin
      @(posedge clk);
      rx_bit_valid <= 1'b1;
      rx_bit <= v[i];
    end
    @(posedge clk);
    rx_bit_valid <= 1'b0;
    @(negedge clk);
  endtask : bits
  // one-cycle packet event: sel is {end, address, header}
  task automatic ev(input logic [2:0] sel, input logic [7:0] d,
    input logic ok);
    @(posedge clk);
    {rx_end, addr_valid, hdr_valid} <= sel;
    hdr_byte <= d;
    addr_byte <= d;
    crc_ok <= ok;
    @(posedge clk);
    {rx_end, addr_valid, hdr_valid} <= 3'b000;
    @(negedge clk);
  endtask : ev
  // request held until ready is seen high at an edge
  task automatic push(input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk);
    in_valid <= 1'b1;
    in_data <= d;
    do begin
      @(posedge clk);
      n++;
    end while (in_ready !== 1'b1 && n < 50);
    in_valid <= 1'b0;
    if (in_ready !== 1'b1) begin
      fail_count++;
      wrap_up();
    end
  endtask : push
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_regs;
    rd("sync_hi", 6'h04, 8'hD3);
    rd("sync_lo", 6'h05, 8'h91);
    rd("len_lim", 6'h06, 8'hFF);
    rd("rx_ctrl", 6'h07, 8'h04);
    rd("fmt_ctrl", 6'h08, 8'h45);
    rd("dev_addr", 6'h09, 8'h00);
    wr(6'h07, 8'hFF);
    rd("rx_mask", 6'h07, 8'hEF);
    wr(6'h08, 8'hFF);
    rd("fmt_mask", 6'h08, 8'h77);
    wr(6'h0A, 8'h55);
    rd("unmapped", 6'h0A, 8'h00);
    wr(6'h04, 8'h3C);
    wr(6'h05, 8'hA5);
    // the decoded view is launched by the write edge itself
    @(negedge clk);
    chk("sync_cfg", 8'h3C, cfg.sync_word[15:8]);
    chk("sync_cfg", 8'hA5, cfg.sync_word[7:0]);
    wr(6'h07, 8'h04);
    wr(6'h08, 8'h45);
    $display("done registers");
  endtask : t_regs
  task automatic t_len;
    wr(6'h06, 8'h20);
    ev(3'b001, 8'h20, 1'b0);
    chk("var_len", 8'h20, pkt_len);
    chk("var_ok", 8'h01, {7'h00, len_ok});
    ev(3'b001, 8'h21, 1'b0);
    chk("var_over", 8'h00, {7'h00, len_ok});
    wr(6'h08, 8'h44);
    ev(3'b001, 8'h07, 1'b0);
    chk("fix_len", 8'h20, pkt_len);
    chk("fix_ok", 8'h01, {7'h00, len_ok});
    wr(6'h08, 8'h46);
    ev(3'b001, 8'h07, 1'b0);
    chk("inf", 8'h01, {7'h00, len_infinite});
    wr(6'h08, 8'h47);
    ev(3'b001, 8'h07, 1'b0);
    chk("reserved", 8'h00, {7'h00, len_ok});
    wr(6'h08, 8'h45);
    $display("done length");
  endtask : t_len
  task automatic t_quality;
    wr(6'h04, 8'hAA);
    wr(6'h05, 8'hAA);
    wr(6'h07, 8'h24);
    bits(16'h0005, 3);
    chk("gate3", 8'h00, {7'h00, sync_allowed});
    bits(16'h0000, 1);
    chk("gate4", 8'h01, {7'h00, sync_allowed});
    bits(16'h0000, 1);
    chk("gate_dn", 8'h00, {7'h00, sync_allowed});
    bits(16'hAAAA, 16);
    chk("hit_open", 8'h01, {7'h00, sync_hit});
    wr(6'h04, 8'h00);
    wr(6'h05, 8'h00);
    bits(16'h0000, 16);
    chk("hit_shut", 8'h00, {7'h00, sync_hit});
    wr(6'h07, 8'h04);
    bits(16'h0000, 1);
    chk("hit_pqt0", 8'h01, {7'h00, sync_hit});
    $display("done quality");
  endtask : t_quality
  task automatic t_addr;
    logic [7:0] al[4] = '{8'h5A, 8'h00, 8'hFF, 8'h33};
    logic e;
    wr(6'h09, 8'h5A);
    for (int m = 0; m < 4; m++) begin
      wr(6'h07, 8'h04 | 8'(m));
      for (int j = 0; j < 4; j++) begin
        e = (m == 0) || (al[j] == 8'h5A) || (m >= 2 && al[j] == 8'h00)
          || (m == 3 && al[j] == 8'hFF);
        ev(3'b010, al[j], 1'b0);
        chk("addr_ok", {7'h00, e}, {7'h00, addr_ok});
      end
    end
    $display("done address");
  endtask : t_addr
  // one packet at a time in the receive buffer while discard is on
  task automatic t_end;
    wr(6'h07, 8'h0C);
    ev(3'b100, 8'h00, 1'b0);
    chk("flush", 8'h01, {7'h00, rx_flush});
    chk("st_valid", 8'h01, {7'h00, status_valid});
    chk("st_rssi", 8'h9C, status_rssi);
    chk("st_lqi", 8'h45, status_lqi_crc);
    ev(3'b100, 8'h00, 1'b1);
    chk("no_flush", 8'h00, {7'h00, rx_flush});
    chk("st_crc", 8'hC5, status_lqi_crc);
    wr(6'h07, 8'h08);
    ev(3'b100, 8'h00, 1'b0);
    chk("no_append", 8'h00, {7'h00, status_valid});
    wr(6'h07, 8'h0C);
    wr(6'h08, 8'h41);
    ev(3'b100, 8'h00, 1'b1);
    chk("crc_off", 8'h45, status_lqi_crc);
    ev(3'b100, 8'h00, 1'b0);
    chk("off_flush", 8'h00, {7'h00, rx_flush});
    wr(6'h07, 8'h04);
    $display("done packet end");
  endtask : t_end
  task automatic t_tx;
    int n;
    logic [8:0] s;
    wr(6'h08, 8'h04);
    push(8'hA1);
    push(8'hB2);
    @(negedge clk);
    chk("full", 8'h00, {7'h00, in_ready});
    stall <= 1'b0;
    push(8'hC3);
    n = 0;
    while (sink_u.got.size() < 3 && n < 50) begin
      @(posedge clk);
      n++;
    end
    if (sink_u.got.size() < 3) begin
      fail_count++;
      wrap_up();
    end
    chk("tx0", 8'hA1, sink_u.got[0]);
    chk("tx1", 8'hB2, sink_u.got[1]);
    chk("tx2", 8'hC3, sink_u.got[2]);
    pin_in <= 1'b1;
    for (int f = 0; f < 4; f++) begin
      wr(6'h08, {2'b00, 2'(f), 4'h4});
      // mode flag is registered from the decoded view, one edge later
      @(posedge clk);
      @(negedge clk);
      chk("serial", {7'h00, f[0]}, {7'h00, serial_mode});
    end
    chk("pin", 8'h01, {7'h00, pin_out});
    // both generators have stepped once per accepted byte so far
    s = lfsr8(lfsr8(lfsr8(PN9_SEED)));
    wr(6'h08, 8'h24);
    push(8'h00);
    wr(6'h08, 8'h44);
    push(8'h0F);
    n = 0;
    while (sink_u.got.size() < 5 && n < 50) begin
      @(posedge clk);
      n++;
    end
    if (sink_u.got.size() < 5) begin
      fail_count++;
      wrap_up();
    end
    chk("tx_random", s[7:0], sink_u.got[3]);
    s = lfsr8(s);
    chk("tx_white", 8'h0F ^ s[7:0], sink_u.got[4]);
    $display("done transmit");
  endtask : t_tx
  // ----------------------------------------
  // main sequence and watchdog
  // ----------------------------------------
  initial begin
    repeat (8) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    t_regs();
    t_len();
    t_quality();
    t_addr();
    t_end();
    t_tx();
    wrap_up();
  end
  initial begin
    repeat (60000) @(posedge clk);
    fail_count++;
    wrap_up();
  end
endmodule : packet_handling_config_tb
`default_nettype wire
